/* File: core/scp_map.svh */
// Character codes, command letters and sizes for the serial command parser
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ----------------------------------------------------------------------------
// Control, punctuation, digit and letter characters
// ----------------------------------------------------------------------------
`define SCP_CH_CR     8'h0D
`define SCP_CH_LF     8'h0A
`define SCP_CH_BS     8'h08
`define SCP_CH_ESC    8'h1B
`define SCP_CH_SP     8'h20
`define SCP_CH_CTL_T  8'h14
`define SCP_CH_CTL_C  8'h03
`define SCP_CH_CTL_P  8'h10
`define SCP_CH_QUOTE  8'h22
`define SCP_CH_QMARK  8'h3F
`define SCP_CH_COLON  8'h3A
`define SCP_CH_PLUS   8'h2B
`define SCP_CH_MINUS  8'h2D
`define SCP_CH_DOT    8'h2E
`define SCP_CH_ZERO   8'h30
`define SCP_CH_X      8'h58
`define SCP_CH_O      8'h4F
`define SCP_CH_N      8'h4E
`define SCP_CH_F      8'h46
`define SCP_CH_K      8'h4B
`define SCP_CH_TILDE  8'h7E

// ----------------------------------------------------------------------------
// Command type letters
// ----------------------------------------------------------------------------
`define SCP_CMD_CAL   8'h43
`define SCP_CMD_DIAG  8'h44
`define SCP_CMD_LOGON 8'h4C
`define SCP_CMD_TEST  8'h54
`define SCP_CMD_VAR   8'h56
`define SCP_CMD_WARN  8'h57

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define SCP_LINE_DEPTH 64
`define SCP_MAX_ARGS   4
`define SCP_ID_DIGITS  4
`define SCP_HELP_LEN   15
`define SCP_MSG_LEN    21

`endif

/* File: core/scp_pkg.sv */
// Types shared by the serial command parser
package scp_pkg;

  // Gray-coded along collect -> parse -> report -> message; report -> help flips two bits
  typedef enum logic [2:0] {
    ST_COLLECT = 3'h0,
    ST_PARSE   = 3'h1,
    ST_REPORT  = 3'h3,
    ST_MSG     = 3'h2,
    ST_HELP    = 3'h6
  } scp_state_t;

  typedef enum logic [2:0] {
    ARG_NAME  = 3'h0,
    ARG_INT   = 3'h1,
    ARG_HEX   = 3'h2,
    ARG_FLOAT = 3'h3,
    ARG_BOOL  = 3'h4,
    ARG_STR   = 3'h5
  } scp_arg_t;

endpackage : scp_pkg

/* File: core/scp_parser.sv */
// Serial command line interpreter: editing, help listing, parsing, replies
//
// Overview of operation
// - Control-T enters echoing interactive mode, flags off.
// - Control-C outside help enters silent computer mode.
// - Nothing executes until carriage return arrives.
// - Backspace removes last character in interactive mode.
// - Escape discards whole pending line in interactive.
// - Question mark command outputs full command list.
// - Control-C pauses listing, Control-P resumes it.
// - Act only on own unit number or none.
// - Letters and keywords matched case-insensitively.
// - Fields are split on single space characters.
// - First field is one valid type letter.
// - Integer: optional sign then one+ digits.
// - Hex: 0x then hex digits, no sign.
// - Float: sign, digits, point, digits; no exponent.
// - Boolean is only ON or OFF.
// - String: quote, printable characters, closing quote.
// - Names compared only at full length.
// - Replies: type, DDD:HH:MM stamp, unit, text, CRLF.
`timescale 1ns/1ps
`include "scp_map.svh"

module scp_parser
  import scp_pkg::*;
#(
  parameter int LINE_DEPTH = `SCP_LINE_DEPTH,
  parameter int IW         = $clog2(LINE_DEPTH) + 1
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // Received characters
  input  wire logic            rx_valid,
  input  wire logic [7:0]      rx_data,
  output logic                 rx_ready,
  // Transmitted characters
  output logic                 tx_valid,
  output logic [7:0]           tx_data,
  input  wire logic            tx_ready,
  // Configuration and time stamp (BCD)
  input  wire logic            cfg_flag1,
  input  wire logic            cfg_flag2,
  input  wire logic [15:0]     unit_id,
  input  wire logic [11:0]     ts_day,
  input  wire logic [7:0]      ts_hour,
  input  wire logic [7:0]      ts_min,
  // Mode status
  output logic                 interactive,
  output logic                 help_active,
  output logic                 help_paused,
  // Parsed command
  output logic                 cmd_valid,
  output logic                 cmd_reject,
  output logic [7:0]           cmd_type,
  output logic [IW-1:0]        cmd_kw_start,
  output logic [IW-1:0]        cmd_kw_len,
  output logic [2:0]           cmd_arg_cnt,
  output logic [11:0]          cmd_arg_kinds,
  // Line buffer read-back for the executor
  input  wire logic [IW-2:0]   rd_idx,
  output logic [7:0]           rd_char
);

  // --------------------------------------------------------------------------
  // Character helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] to_up(input logic [7:0] c);
    to_up = (c >= 8'h61 && c <= 8'h7A) ? (c & 8'hDF) : c;
  endfunction : to_up

  function automatic logic is_dig(input logic [7:0] c);
    is_dig = (c >= `SCP_CH_ZERO) && (c <= 8'h39);
  endfunction : is_dig

  function automatic logic is_hexd(input logic [7:0] c);
    is_hexd = is_dig(c) || (to_up(c) >= 8'h41 && to_up(c) <= `SCP_CH_F);
  endfunction : is_hexd

  function automatic logic [7:0] help_char(input logic [4:0] i);
    case (i)
      5'h00:   help_char = `SCP_CMD_CAL;
      5'h02:   help_char = `SCP_CMD_DIAG;
      5'h04:   help_char = `SCP_CMD_LOGON;
      5'h06:   help_char = `SCP_CMD_TEST;
      5'h08:   help_char = `SCP_CMD_VAR;
      5'h0A:   help_char = `SCP_CMD_WARN;
      5'h0C:   help_char = `SCP_CH_QMARK;
      5'h0D:   help_char = `SCP_CH_CR;
      5'h0E:   help_char = `SCP_CH_LF;
      default: help_char = `SCP_CH_SP;
    endcase
  endfunction : help_char

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  scp_state_t        st_r;
  logic [7:0]        line_r [LINE_DEPTH];
  logic [IW-1:0]     len_r;
  logic              ovf_r;
  logic              echo_pend_r;
  logic [7:0]        echo_r;
  logic [4:0]        out_idx_r;
  logic [IW-1:0]     pidx_r;
  logic [2:0]        fld_r;
  logic [IW-1:0]     f_len_r;
  logic [7:0]        f_first_r;
  logic [23:0]       f_word_r;
  logic              f_int_r, f_hex_r, f_flt_r, f_dot_r, f_dig_r, f_cls_r, f_bad_r;
  logic [15:0]       id_acc_r;
  logic              err_r, foreign_r, help_cmd_r, kw_seen_r, id_seen_r;

  wire logic take     = rx_valid && rx_ready;
  wire logic tx_load  = !tx_valid || tx_ready;
  wire logic help_go  = (st_r == ST_HELP) && !help_paused && !echo_pend_r && tx_load;
  wire logic msg_go   = (st_r == ST_MSG) && !echo_pend_r && tx_load;
  wire logic out_last = (help_go && out_idx_r == 5'(`SCP_HELP_LEN - 1))
                     || (msg_go && out_idx_r == 5'(`SCP_MSG_LEN - 1));
  wire logic at_end   = (pidx_r == len_r);
  wire logic [7:0] pc = at_end ? `SCP_CH_SP : line_r[pidx_r[IW-2:0]];
  wire logic in_str   = (f_len_r != '0) && (f_first_r == `SCP_CH_QUOTE) && !f_cls_r;
  wire logic sep      = at_end || (pc == `SCP_CH_SP && !in_str);
  wire logic fin_err  = err_r || (!help_cmd_r && !kw_seen_r);

  // Reply text: type letter, day:hour:minute, unit, fixed text, CR LF
  function automatic logic [7:0] msg_char(input logic [4:0] i);
    case (i)
      5'h00:   msg_char = cmd_type;
      5'h02:   msg_char = {4'h3, ts_day[11:8]};
      5'h03:   msg_char = {4'h3, ts_day[7:4]};
      5'h04:   msg_char = {4'h3, ts_day[3:0]};
      5'h05:   msg_char = `SCP_CH_COLON;
      5'h06:   msg_char = {4'h3, ts_hour[7:4]};
      5'h07:   msg_char = {4'h3, ts_hour[3:0]};
      5'h08:   msg_char = `SCP_CH_COLON;
      5'h09:   msg_char = {4'h3, ts_min[7:4]};
      5'h0A:   msg_char = {4'h3, ts_min[3:0]};
      5'h0C:   msg_char = {4'h3, unit_id[15:12]};
      5'h0D:   msg_char = {4'h3, unit_id[11:8]};
      5'h0E:   msg_char = {4'h3, unit_id[7:4]};
      5'h0F:   msg_char = {4'h3, unit_id[3:0]};
      5'h11:   msg_char = `SCP_CH_O;
      5'h12:   msg_char = `SCP_CH_K;
      5'h13:   msg_char = `SCP_CH_CR;
      5'h14:   msg_char = `SCP_CH_LF;
      default: msg_char = `SCP_CH_SP;
    endcase
  endfunction : msg_char

  // --------------------------------------------------------------------------
  // Terminal mode
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      interactive <= 1'b0;
    end else if (cfg_flag1 || cfg_flag2) begin
      interactive <= 1'b0;
    end else if (take && rx_data == `SCP_CH_CTL_T) begin
      interactive <= 1'b1;
    end else if (take && rx_data == `SCP_CH_CTL_C && st_r != ST_HELP) begin
      interactive <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      help_paused <= 1'b0;
    end else if (st_r != ST_HELP) begin
      help_paused <= 1'b0;
    end else if (take && rx_data == `SCP_CH_CTL_C) begin
      help_paused <= 1'b1;
    end else if (take && rx_data == `SCP_CH_CTL_P) begin
      help_paused <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Line collection and sequencing
  // --------------------------------------------------------------------------
  // Ready drops for one cycle after each taken byte, and longer while an echo is queued
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_ready <= 1'b0;
    end else begin
      rx_ready <= (st_r == ST_COLLECT || st_r == ST_HELP) && !echo_pend_r && !take;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r  <= ST_COLLECT;
      len_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      case (st_r)
        ST_COLLECT: begin
          if (take) begin
            if (rx_data == `SCP_CH_CR) begin
              if (len_r != '0) begin
                st_r <= ST_PARSE;
              end
            end else if (rx_data == `SCP_CH_CTL_T || rx_data == `SCP_CH_CTL_C
                         || rx_data == `SCP_CH_CTL_P) begin
              len_r <= len_r;
            end else if (interactive && rx_data == `SCP_CH_BS) begin
              if (len_r != '0) begin
                len_r <= len_r - 1'b1;
              end
            end else if (interactive && rx_data == `SCP_CH_ESC) begin
              len_r <= '0;
              ovf_r <= 1'b0;
            end else if (len_r == IW'(LINE_DEPTH)) begin
              ovf_r <= 1'b1;
            end else begin
              line_r[len_r[IW-2:0]] <= rx_data;
              len_r <= len_r + 1'b1;
            end
          end
        end
        ST_PARSE: begin
          if (at_end) begin
            st_r <= ST_REPORT;
          end
        end
        ST_REPORT: begin
          len_r <= '0;
          ovf_r <= 1'b0;
          if (fin_err || foreign_r) begin
            st_r <= ST_COLLECT;
          end else if (help_cmd_r) begin
            st_r <= ST_HELP;
          end else begin
            st_r <= ST_MSG;
          end
        end
        default: begin
          if (out_last) begin
            st_r <= ST_COLLECT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_char <= 8'h00;
    end else begin
      rd_char <= line_r[rd_idx];
    end
  end

  // --------------------------------------------------------------------------
  // Field splitting and argument checks
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pidx_r <= '0; fld_r <= '0; f_len_r <= '0; f_first_r <= 8'h00; f_word_r <= 24'h0;
      f_int_r <= 1'b0; f_hex_r <= 1'b0; f_flt_r <= 1'b0; f_dot_r <= 1'b0;
      f_dig_r <= 1'b0; f_cls_r <= 1'b0; f_bad_r <= 1'b0; id_acc_r <= 16'h0;
      err_r <= 1'b0; foreign_r <= 1'b0; help_cmd_r <= 1'b0;
      kw_seen_r <= 1'b0; id_seen_r <= 1'b0;
      cmd_type <= 8'h00; cmd_kw_start <= '0; cmd_kw_len <= '0;
      cmd_arg_cnt <= 3'h0; cmd_arg_kinds <= 12'h000;
    end else if (st_r == ST_COLLECT) begin
      pidx_r <= '0; fld_r <= '0; f_len_r <= '0; f_bad_r <= 1'b0; f_cls_r <= 1'b0;
      f_dot_r <= 1'b0; f_dig_r <= 1'b0; id_acc_r <= 16'h0;
      err_r <= ovf_r; foreign_r <= 1'b0; help_cmd_r <= 1'b0;
      kw_seen_r <= 1'b0; id_seen_r <= 1'b0;
      cmd_arg_cnt <= 3'h0; cmd_arg_kinds <= 12'h000;
    end else if (st_r == ST_PARSE) begin
      pidx_r <= pidx_r + 1'b1;
      if (sep) begin
        f_len_r <= '0; f_bad_r <= 1'b0; f_cls_r <= 1'b0;
        f_dot_r <= 1'b0; f_dig_r <= 1'b0; id_acc_r <= 16'h0;
        fld_r <= (fld_r == 3'h7) ? fld_r : fld_r + 1'b1;
        if (f_len_r == '0) begin
          err_r <= 1'b1;
        end else if (fld_r == 3'h0) begin
          cmd_type <= to_up(f_first_r);
          help_cmd_r <= (f_first_r == `SCP_CH_QMARK);
          if (f_len_r != IW'(1) || !(f_first_r == `SCP_CH_QMARK
              || to_up(f_first_r) == `SCP_CMD_CAL || to_up(f_first_r) == `SCP_CMD_DIAG
              || to_up(f_first_r) == `SCP_CMD_LOGON || to_up(f_first_r) == `SCP_CMD_TEST
              || to_up(f_first_r) == `SCP_CMD_VAR || to_up(f_first_r) == `SCP_CMD_WARN)) begin
            err_r <= 1'b1;
          end
        end else if (fld_r == 3'h1 && f_int_r && f_dig_r && is_dig(f_first_r)) begin
          id_seen_r <= 1'b1;
          if (f_len_r > IW'(`SCP_ID_DIGITS)) begin
            err_r <= 1'b1;
          end else if (id_acc_r != unit_id) begin
            foreign_r <= 1'b1;
          end
        end else if (help_cmd_r) begin
          err_r <= 1'b1;
        end else if (!kw_seen_r) begin
          kw_seen_r <= 1'b1;
          cmd_kw_start <= pidx_r - f_len_r;
          cmd_kw_len <= f_len_r;
          if (to_up(f_first_r) < 8'h41 || to_up(f_first_r) > 8'h5A) begin
            err_r <= 1'b1;
          end
        end else if (cmd_arg_cnt == 3'(`SCP_MAX_ARGS)) begin
          err_r <= 1'b1;
        end else begin
          cmd_arg_cnt <= cmd_arg_cnt + 1'b1;
          if (f_hex_r && f_len_r >= IW'(3)) begin
            cmd_arg_kinds[3*cmd_arg_cnt +: 3] <= ARG_HEX;
          end else if (f_int_r && f_dig_r) begin
            cmd_arg_kinds[3*cmd_arg_cnt +: 3] <= ARG_INT;
          end else if (f_flt_r && f_dig_r) begin
            cmd_arg_kinds[3*cmd_arg_cnt +: 3] <= ARG_FLOAT;
          end else if (f_cls_r && !f_bad_r && f_len_r >= IW'(3)) begin
            cmd_arg_kinds[3*cmd_arg_cnt +: 3] <= ARG_STR;
          end else if ((f_len_r == IW'(2) && f_word_r[15:0] == {`SCP_CH_O, `SCP_CH_N})
                       || (f_len_r == IW'(3)
                       && f_word_r == {`SCP_CH_O, `SCP_CH_F, `SCP_CH_F})) begin
            cmd_arg_kinds[3*cmd_arg_cnt +: 3] <= ARG_BOOL;
          end else if (is_dig(f_first_r) || f_first_r == `SCP_CH_PLUS
                       || f_first_r == `SCP_CH_MINUS || f_first_r == `SCP_CH_DOT
                       || f_first_r == `SCP_CH_QUOTE) begin
            err_r <= 1'b1;
          end else begin
            cmd_arg_kinds[3*cmd_arg_cnt +: 3] <= ARG_NAME;
          end
        end
      end else begin
        f_len_r  <= f_len_r + 1'b1;
        f_word_r <= (f_len_r < IW'(3)) ? {f_word_r[15:0], to_up(pc)} : f_word_r;
        f_dig_r  <= f_dig_r || is_dig(pc);
        f_dot_r  <= f_dot_r || (pc == `SCP_CH_DOT);
        id_acc_r <= {id_acc_r[11:0], pc[3:0]};
        if (pc < `SCP_CH_SP || pc > `SCP_CH_TILDE || f_cls_r) begin
          f_bad_r <= 1'b1;
        end
        if (f_len_r == '0) begin
          f_first_r <= pc;
          f_int_r <= is_dig(pc) || pc == `SCP_CH_PLUS || pc == `SCP_CH_MINUS;
          f_hex_r <= (pc == `SCP_CH_ZERO);
          f_flt_r <= is_dig(pc) || pc == `SCP_CH_PLUS || pc == `SCP_CH_MINUS
                     || pc == `SCP_CH_DOT;
        end else begin
          f_int_r <= f_int_r && is_dig(pc);
          f_hex_r <= f_hex_r && ((f_len_r == IW'(1)) ? (to_up(pc) == `SCP_CH_X)
                                                     : is_hexd(pc));
          f_flt_r <= f_flt_r && (is_dig(pc) || (pc == `SCP_CH_DOT && !f_dot_r));
          if (f_first_r == `SCP_CH_QUOTE && pc == `SCP_CH_QUOTE && !f_cls_r) begin
            f_cls_r <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_valid  <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_valid  <= (st_r == ST_REPORT) && !fin_err && !foreign_r && !help_cmd_r;
      cmd_reject <= (st_r == ST_REPORT) && fin_err;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      help_active <= 1'b0;
    end else begin
      help_active <= (st_r == ST_HELP) && !out_last;
    end
  end

  // --------------------------------------------------------------------------
  // Transmit: echo first, then help listing or reply
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      echo_pend_r <= 1'b0;
      echo_r      <= 8'h00;
    end else if (take && st_r == ST_COLLECT && interactive
                 && rx_data >= `SCP_CH_SP && rx_data <= `SCP_CH_TILDE) begin
      echo_pend_r <= 1'b1;
      echo_r      <= rx_data;
    end else if (take && st_r == ST_COLLECT && interactive
                 && (rx_data == `SCP_CH_BS || rx_data == `SCP_CH_CR)) begin
      echo_pend_r <= 1'b1;
      echo_r      <= rx_data;
    end else if (echo_pend_r && tx_load) begin
      echo_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      out_idx_r <= 5'h00;
    end else begin
      if (st_r == ST_REPORT || out_last) begin
        out_idx_r <= 5'h00;
      end else if (help_go || msg_go) begin
        out_idx_r <= out_idx_r + 1'b1;
      end
      if (tx_load) begin
        tx_valid <= echo_pend_r || help_go || msg_go;
        if (echo_pend_r) begin
          tx_data <= echo_r;
        end else if (help_go) begin
          tx_data <= help_char(out_idx_r);
        end else if (msg_go) begin
          tx_data <= msg_char(out_idx_r);
        end
      end
    end
  end

endmodule : scp_parser

/* File: tb/scp_parser_properties.sv */
// Port properties of the serial command parser
`timescale 1ns/1ps
module scp_parser_properties (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Character links
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  // Mode and verdicts
  input wire logic       interactive,
  input wire logic       help_active,
  input wire logic       help_paused,
  input wire logic       cmd_valid,
  input wire logic       cmd_reject
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       take;
  logic       calm;
  logic       cr_r;
  logic [7:0] last_r;
  assign take = rx_valid && rx_ready;
  assign calm = !help_active && !help_paused;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) last_r <= 8'h00;
    else if (take) last_r <= rx_data;
  end
  // Set by a taken carriage return, cleared by the verdict it allows
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cr_r <= 1'b0;
    else if (take && rx_data == 8'h0D) cr_r <= 1'b1;
    else if (cmd_valid || cmd_reject) cr_r <= 1'b0;
  end
  AST_ECHO: assert property (take && interactive && calm && rx_data inside {[8'h21:8'h7E]}
    |-> ##[1:3] tx_valid && tx_data == last_r) else $error("echo missing");
  AST_QUIET: assert property (take && !interactive && calm |=> !tx_valid [*2])
    else $error("echo in computer mode");
  AST_COMPUTER: assert property (take && rx_data == 8'h03 && calm |-> ##[1:3] !interactive)
    else $error("no computer mode");
  AST_PAUSE: assert property (take && rx_data == 8'h03 && help_active |-> ##[1:3] help_paused)
    else $error("listing not paused");
  AST_RESUME: assert property (take && rx_data == 8'h10 && help_paused |-> ##[1:3] !help_paused)
    else $error("listing not resumed");
  AST_CR_FIRST: assert property (cmd_valid || cmd_reject |-> cr_r)
    else $error("verdict without carriage return");
  AST_ONE_VERDICT: assert property (cmd_valid || cmd_reject |-> !(cmd_valid && cmd_reject)
    ##1 !cmd_valid && !cmd_reject) else $error("bad verdict pulse");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte withdrawn");
  cover property (cmd_valid);
  cover property (cmd_reject);
  cover property (help_paused);
endmodule : scp_parser_properties

bind scp_parser scp_parser_properties i_props (.mclk(mclk), .rst(rst), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .interactive(interactive), .help_active(help_active),
  .help_paused(help_paused), .cmd_valid(cmd_valid), .cmd_reject(cmd_reject));

/* File: tb/scp_term.sv */
// Terminal model: sends command lines and logs what the parser transmits
`timescale 1ns/1ps
module scp_term (
  // Clock
  input wire logic       mclk,
  // Towards the parser
  output logic           rx_valid,
  output logic [7:0]     rx_data,
  input wire logic       rx_ready,
  // From the parser
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  output logic           tx_ready
);
  logic [7:0] tx_log[$];
  logic       stall = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    tx_ready = 1'b1;
  end
  // A slow host toggles ready, so every byte must stand a cycle
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) tx_log.push_back(tx_data);
    tx_ready <= stall ? !tx_ready : 1'b1;
  end
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(posedge mclk);
    while (rx_ready !== 1'b1) @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data  <= ~b;  // Released line never keeps the byte just sent
  endtask : send
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) send(s[i]);
    send(8'h0D);
  endtask : send_line
endmodule : scp_term

/* File: tb/testbench.sv */
// Self-checking bench for the serial command parser
`timescale 1ns/1ps
module testbench;
  import scp_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        flag1 = 1'b0;
  logic        flag2 = 1'b0;
  logic [15:0] uid = 16'h0200;
  logic [11:0] day = 12'h123;
  logic [7:0]  hour = 8'h04;
  logic [7:0]  minute = 8'h59;
  logic [5:0]  rd_idx = 6'h00;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, interactive, help_active;
  logic        help_paused, cmd_valid, cmd_reject;
  logic [7:0]  rx_data, tx_data, cmd_type, rd_char;
  logic [6:0]  kw_start, kw_len;
  logic [2:0]  arg_cnt;
  logic [11:0] kinds;
  logic [1:0]  v;
  int          err_count = 0;
  int          comparisons = 0;
  always #50 mclk = ~mclk;
  scp_parser i_dut (.mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .cfg_flag1(flag1), .cfg_flag2(flag2), .unit_id(uid), .ts_day(day),
    .ts_hour(hour), .ts_min(minute), .interactive(interactive), .help_active(help_active),
    .help_paused(help_paused), .cmd_valid(cmd_valid), .cmd_reject(cmd_reject),
    .cmd_type(cmd_type), .cmd_kw_start(kw_start), .cmd_kw_len(kw_len),
    .cmd_arg_cnt(arg_cnt), .cmd_arg_kinds(kinds), .rd_idx(rd_idx), .rd_char(rd_char));
  scp_term i_term (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // Verdict code: 01 accepted, 10 discarded, 00 silent
  task automatic wait_verdict();
    v = 2'b00;
    repeat (200) if (v == 2'b00) @(posedge mclk) v = {cmd_reject, cmd_valid};
  endtask : wait_verdict
  task automatic t_reply();
    string r = "V 123:04:59 0200 OK\015\012";
    i_term.tx_log.delete();
    i_term.send_line("v 200 x");
    wait_verdict();
    check("reply verdict", {v, arg_cnt}, 5'h08);
    repeat (100) @(posedge mclk);
    check("reply size", i_term.tx_log.size(), 21);
    for (int i = 0; i < 21; i++) check("reply", i_term.tx_log[i], r[i]);
  endtask : t_reply
  task automatic t_formats();
    string      ln[13] = '{"c k +12", "d k 0x1aF", "l k -0x1", "t k -.5", "v k 1e5",
      "W k off", "w k ON", "D k \"a b\"", "L k \"\"", "V k ONX", "x k", "c  k", "t 201 k"};
    logic [3:0] ek[13] = '{ARG_INT, ARG_HEX, 4'h8, ARG_FLOAT, 4'h8, ARG_BOOL, ARG_BOOL,
      ARG_STR, 4'h8, ARG_NAME, 4'h8, 4'h8, 4'h9};
    for (int i = 0; i < 13; i++) begin
      i_term.send_line(ln[i]);
      wait_verdict();
      check(ln[i], v, ek[i] == 4'h8 ? 2'b10 : (ek[i] == 4'h9 ? 2'b00 : 2'b01));
      if (!ek[i][3])
        check(ln[i], {cmd_type, kinds[2:0]}, {ln[i][0] & 8'hDF, ek[i][2:0]});
    end
    uid <= 16'h0201;
    i_term.send_line("t 201 k");
    wait_verdict();
    check("own id", v, 2'b01);
    uid <= 16'h0200;
  endtask : t_formats
  task automatic t_edit();
    flag1 <= 1'b1;
    i_term.send(8'h14);
    repeat (4) @(posedge mclk);
    check("flag set", interactive, 1'b0);
    flag1 <= 1'b0;
    flag2 <= 1'b1;
    i_term.send(8'h14);
    repeat (4) @(posedge mclk);
    check("flag2 set", interactive, 1'b0);
    flag2 <= 1'b0;
    i_term.send(8'h14);
    repeat (4) @(posedge mclk);
    check("terminal", interactive, 1'b1);
    i_term.send_line("jk\033tQ\010 k");
    wait_verdict();
    check("edited", {v, cmd_type, kw_start, kw_len}, {2'b01, 8'h54, 7'h02, 7'h01});
    rd_idx <= kw_start[5:0];
    repeat (2) @(posedge mclk);
    check("kw char", rd_char, 8'h6B);
    i_term.send(8'h03);
    repeat (4) @(posedge mclk);
    check("computer", interactive, 1'b0);
  endtask : t_edit
  task automatic t_help();
    i_term.tx_log.delete();
    i_term.stall <= 1'b1;
    i_term.send_line("?");
    repeat (12) @(posedge mclk);
    i_term.send(8'h03);
    repeat (30) @(posedge mclk);
    check("paused", {help_active, help_paused, i_term.tx_log.size() < 15}, 3'h7);
    i_term.send(8'h10);
    repeat (60) @(posedge mclk);
    check("listing", {help_active, i_term.tx_log.size() == 15}, 2'b01);
    check("list end", {i_term.tx_log[13], i_term.tx_log[14]}, 16'h0D0A);
    i_term.stall <= 1'b0;
  endtask : t_help
  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check("reset", {interactive, help_active, cmd_valid, tx_valid}, 4'h0);
    t_reply();
    t_formats();
    t_edit();
    t_help();
    print_verdict();
  end
  // The whole run needs about a thousand cycles; allow thirty thousand cycles
  initial begin
    #3000000;
    err_count++;
    print_verdict();
  end
endmodule : testbench
